// ===== verilog/pimc_pkg.sv
// Constants and types shared by the PDM input mode control block
package pimc_pkg;

   // Clock and timing
   localparam int         CLK_NS      = 25;
   localparam int         T_ON_MS     = 2;
   localparam int         TON_CYC_DEF = T_ON_MS * 1000000 / CLK_NS;
   localparam int         T_OFF_US    = 5;
   localparam int         TOFF_CYC    = T_OFF_US * 1000 / CLK_NS;
   localparam int         LOSS_NS     = 2000;
   localparam logic [7:0] LOSS_CYC    = 8'((LOSS_NS + CLK_NS - 1) / CLK_NS);

   // Pattern run lengths
   localparam logic [7:0] MUTE_CNT = 8'h20;
   localparam logic [7:0] PD_CNT   = 8'h80;
   localparam logic [7:0] SET_CNT  = 8'h80;
   localparam logic [7:0] RUN_MAX  = 8'hff;
   localparam int         BYTE_W   = 8;

   // Silence pattern table and its indices
   localparam int         NPAT = 9;
   localparam logic [7:0] PAT_TAB [NPAT] = '{8'hd2, 8'hd4, 8'hd8, 8'he1, 8'he2,
                                             8'he4, 8'haa, 8'h66, 8'hac};
   localparam logic [3:0] ID_CLIP  = 4'h0;
   localparam logic [3:0] ID_GM3   = 4'h1;
   localparam logic [3:0] ID_GP3   = 4'h2;
   localparam logic [3:0] ID_SLOPE = 4'h3;
   localparam logic [3:0] ID_DPSA  = 4'h4;
   localparam logic [3:0] ID_BWE   = 4'h5;
   localparam logic [3:0] ID_DEF   = 4'h6;
   localparam logic [3:0] ID_MUTE  = 4'h7;
   localparam logic [3:0] ID_PD    = 4'h8;
   localparam logic [3:0] ID_NONE  = 4'hf;

   // Register map
   localparam logic [11:0] ADDR_CTRL  = 12'h000;
   localparam logic [11:0] ADDR_STAT  = 12'h004;
   localparam int          CTRL_EN    = 0;
   localparam int          CTRL_DEF   = 1;
   localparam logic        CTRL_EN_RST = 1'b1;
   localparam int          STAT_MODE  = 0;
   localparam int          STAT_GAIN  = 4;
   localparam int          STAT_CLIP  = 6;
   localparam int          STAT_SLOPE = 7;
   localparam int          STAT_DPSA  = 8;
   localparam int          STAT_BWE   = 9;
   localparam int          STAT_CLK   = 10;
   localparam int          STAT_FLT   = 11;

   // Audio path
   localparam int          NFLT      = 4;
   localparam int          HPF_SHIFT = 6;
   localparam int          LPF_SHIFT = 4;
   localparam int          DUTY_SH   = 9;
   localparam logic [17:0] AMP_POS   = 18'h04000;
   localparam logic [17:0] AMP_NEG   = 18'h3c000;
   localparam logic [7:0]  CLIP_LIM  = 8'h64;
   localparam logic [7:0]  DUTY_MAX  = 8'h7f;
   localparam logic [8:0]  PWM_MID   = 9'h080;

   typedef enum logic [2:0] {MD_PD_CLK, MD_POWERUP, MD_OPER, MD_MUTE, MD_PD_PAT, MD_FAULT} pimc_mode_e;
   typedef enum logic [1:0] {G_M3DB, G_0DB, G_P3DB} pimc_gain_e;

endpackage : pimc_pkg

// ===== verilog/pimc_rot_match.sv
// Byte matcher that accepts a pattern in any bit rotation
`timescale 1ns/1ps
module pimc_rot_match #(
   parameter logic [7:0] PATTERN = 8'h00
) (
   input  logic [7:0] byte_in,
   output logic       hit
);
   import pimc_pkg::*;

   // Compare against all eight rotations
   always_comb begin
      logic [15:0] dbl;
      dbl = 16'h0000;
      hit = 1'b0;
      for (int r = 0; r < BYTE_W; r++) begin
         dbl = {PATTERN, PATTERN} >> (BYTE_W - r);
         if (byte_in == dbl[7:0]) begin
            hit = 1'b1;
         end
      end
   end

endmodule : pimc_rot_match

// ===== verilog/pimc_top.sv
// PDM input mode control: clock watch, pattern modes, DC block, PWM
// Function
// - No bit clock means power-down with both outputs floating.
// - A clock appearing during power-down starts the way to operating.
// - 128 consecutive 0xAC bytes put the device into power-down.
// - Pattern power-down holds while 0xAC continues, any other byte resumes.
// - 32 consecutive 0x66 bytes put the device into mute.
// - Mute holds until a byte other than 0x66 arrives.
// - Mute floats both output stages.
// - Operating drives both outputs with audio from the stream.
// - Any active protection forces a distinct fault state; the code does not enter MD_FAULT from MD_PD_CLK.
// - The stream is high-pass filtered to remove DC.
// - Filtered audio becomes two PWM outputs in three-level modulation.
// - Settings come from silence patterns, defaults otherwise.
// - Gain is selectable as -3, 0 or +3 dB.
// - Operating is reached within 2 ms of power-up.
// - Power-down completes within 5 us.
// - Channel select low takes left, high takes right.
// - Patterns match regardless of byte alignment or rotation.
// - After power-up only mute and power-down patterns act.
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
module pimc_top #(
   parameter int TON_CYC = pimc_pkg::TON_CYC_DEF
) (
   input  logic                      pclk,
   input  logic                      presetn,
   input  logic                      psel,
   input  logic                      penable,
   input  logic                      pwrite,
   input  logic [11:0]               paddr,
   input  logic [31:0]               pwdata,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  logic                      bit_clock,
   input  logic                      data_in,
   input  logic                      channel_select_input,
   input  logic [pimc_pkg::NFLT-1:0] protect_fault,
   output logic                      noninverting_output,
   output logic                      noninverting_output_oe_n,
   output logic                      inverting_output,
   output logic                      inverting_output_oe_n
);
   import pimc_pkg::*;

   localparam int             TON_W  = $clog2(TON_CYC + 1);
   localparam int             A_TOFF = TOFF_CYC;
   localparam logic [TON_W:0] PU_MAX = (TON_W + 1)'(TON_CYC);

   typedef struct packed {
      logic             clk_s1;
      logic             clk_s2;
      logic             clk_s3;
      logic             dat_s1;
      logic             dat_s2;
      logic             lr_s1;
      logic             lr_s2;
      logic [NFLT-1:0]  flt_s1;
      logic [NFLT-1:0]  flt_s2;
      logic [7:0]       idle_cnt;
      pimc_mode_e       mode;
      logic [TON_W-1:0] ton_cnt;
      logic [7:0]       shreg;
      logic [2:0]       bit_cnt;
      logic [3:0]       last_id;
      logic [7:0]       run;
      pimc_gain_e       gain;
      logic             clip_on;
      logic             slope_low;
      logic             dpsa_off;
      logic             bwe_on;
      logic             amp_en;
      logic [31:0]      rdata;
      logic [17:0]      dc;
      logic [17:0]      lvl;
      logic [7:0]       pwm_cnt;
      logic             out_a;
      logic             out_b;
      logic             oe_n;
   } pimc_state_s;

   pimc_state_s     st;
   pimc_state_s     next_st;
   logic            clk_rise;
   logic            clk_fall;
   logic            bit_v;
   logic            byte_v;
   logic            lost;
   logic            flt_any;
   logic [7:0]      byte_nx;
   logic [NPAT-1:0] hits;
   logic [3:0]      hit_id;
   logic [7:0]      run_nx;
   logic            apb_setup;
   logic            apb_wr;
   logic            mapped;

   // Lowest index wins among pattern hits
   function automatic logic [3:0] first_hit(input logic [NPAT-1:0] h);
      logic [3:0] id;
      id = ID_NONE;
      for (int i = NPAT - 1; i >= 0; i--) begin
         if (h[i]) begin
            id = 4'(i);
         end
      end
      return id;
   endfunction : first_hit

   // One matcher per silence pattern
   for (genvar gi = 0; gi < NPAT; gi++) begin : g_match
      pimc_rot_match #(
         .PATTERN (PAT_TAB[gi])
      ) u_match (
         .byte_in (byte_nx),
         .hit     (hits[gi])
      );
   end

   // Edge finding, channel pick and byte assembly
   assign clk_rise = st.clk_s2 & ~st.clk_s3;
   assign clk_fall = ~st.clk_s2 & st.clk_s3;
   assign bit_v    = st.lr_s2 ? clk_fall : clk_rise;
   assign byte_nx  = {st.shreg[6:0], st.dat_s2};
   assign byte_v   = bit_v && (st.bit_cnt == 3'h7);
   assign hit_id   = first_hit(hits);
   assign lost     = (st.idle_cnt >= LOSS_CYC) && !clk_rise && !clk_fall;
   assign flt_any  = |st.flt_s2;

   // Run length of the same pattern, restarted by any other byte
   assign run_nx = (hit_id == ID_NONE) ? 8'h00 :
                   (hit_id != st.last_id) ? 8'h01 :
                   (st.run == RUN_MAX) ? RUN_MAX : st.run + 8'h01;

   // APB slave, no wait states
   assign apb_setup = psel & ~penable;
   assign apb_wr    = psel & penable & pwrite & (paddr == ADDR_CTRL);
   assign mapped    = (paddr == ADDR_CTRL) || (paddr == ADDR_STAT);
   assign pready    = 1'b1;
   assign pslverr   = psel & penable & ~mapped;
   assign prdata    = st.rdata;

   // Output pins
   assign noninverting_output      = st.out_a;
   assign inverting_output         = st.out_b;
   assign noninverting_output_oe_n = st.oe_n;
   assign inverting_output_oe_n    = st.oe_n;

   // Next state of the whole block
   always_comb begin
      logic signed [17:0] samp;
      logic signed [17:0] hp;
      logic signed [17:0] gsig;
      logic signed [17:0] dlt;
      logic signed [17:0] lv;
      logic [7:0]         lim;
      logic [7:0]         duty;
      logic [8:0]         half;
      samp    = 18'h00000;
      hp      = 18'h00000;
      gsig    = 18'h00000;
      dlt     = 18'h00000;
      lv      = 18'h00000;
      lim     = 8'h00;
      duty    = 8'h00;
      half    = 9'h000;
      next_st = st;

      // Pin synchronisers
      next_st.clk_s1 = bit_clock;
      next_st.clk_s2 = st.clk_s1;
      next_st.clk_s3 = st.clk_s2;
      next_st.dat_s1 = data_in;
      next_st.dat_s2 = st.dat_s1;
      next_st.lr_s1  = channel_select_input;
      next_st.lr_s2  = st.lr_s1;
      next_st.flt_s1 = protect_fault;
      next_st.flt_s2 = st.flt_s1;

      // Clock presence watchdog
      if (clk_rise || clk_fall) begin
         next_st.idle_cnt = 8'h00;
      end else if (st.idle_cnt < LOSS_CYC) begin
         next_st.idle_cnt = st.idle_cnt + 8'h01;
      end

      // Bit and byte collection
      if (bit_v) begin
         next_st.shreg   = byte_nx;
         next_st.bit_cnt = st.bit_cnt + 3'h1;
      end
      if (byte_v) begin
         next_st.last_id = hit_id;
         next_st.run     = run_nx;
      end

      // Mode sequencing
      case (st.mode)
         MD_PD_CLK: begin
            if (clk_rise && st.amp_en) begin
               next_st.mode    = MD_POWERUP;
               next_st.ton_cnt = '0;
            end
         end
         MD_POWERUP: begin
            if (st.ton_cnt == TON_W'(TON_CYC - 1)) begin
               next_st.mode = MD_OPER;
            end else begin
               next_st.ton_cnt = st.ton_cnt + 1'b1;
            end
            if (byte_v && run_nx == SET_CNT) begin
               case (hit_id)
                  ID_CLIP:  next_st.clip_on   = 1'b1;
                  ID_GM3:   next_st.gain      = G_M3DB;
                  ID_GP3:   next_st.gain      = G_P3DB;
                  ID_SLOPE: next_st.slope_low = 1'b1;
                  ID_DPSA:  next_st.dpsa_off  = 1'b1;
                  ID_BWE:   next_st.bwe_on    = 1'b1;
                  ID_DEF: begin
                     next_st.gain      = G_0DB;
                     next_st.clip_on   = 1'b0;
                     next_st.slope_low = 1'b0;
                     next_st.dpsa_off  = 1'b0;
                     next_st.bwe_on    = 1'b0;
                  end
                  default: ;
               endcase
            end
         end
         MD_OPER: begin
            // Only mute and power-down patterns act here
            if (byte_v && hit_id == ID_MUTE && run_nx == MUTE_CNT) begin
               next_st.mode = MD_MUTE;
            end else if (byte_v && hit_id == ID_PD && run_nx == PD_CNT) begin
               next_st.mode = MD_PD_PAT;
            end
         end
         MD_MUTE: begin
            if (byte_v && hit_id != ID_MUTE) begin
               next_st.mode = MD_OPER;
            end
         end
         MD_PD_PAT: begin
            if (byte_v && hit_id != ID_PD) begin
               next_st.mode = MD_OPER;
            end
         end
         MD_FAULT: begin
            if (!flt_any) begin
               next_st.mode = MD_OPER;
            end
         end
         default: next_st.mode = MD_PD_CLK;
      endcase

      // Clock loss and protection override the sequence
      if (lost || !st.amp_en) begin
         next_st.mode = MD_PD_CLK;
         next_st.run  = 8'h00;
      end else if (flt_any && st.mode != MD_PD_CLK) begin
         next_st.mode = MD_FAULT;
      end

      // Register writes
      if (apb_wr) begin
         next_st.amp_en = pwdata[CTRL_EN];
         if (pwdata[CTRL_DEF]) begin
            next_st.gain      = G_0DB;
            next_st.clip_on   = 1'b0;
            next_st.slope_low = 1'b0;
            next_st.dpsa_off  = 1'b0;
            next_st.bwe_on    = 1'b0;
         end
      end

      // Read data captured in the setup phase
      if (apb_setup) begin
         next_st.rdata = 32'h00000000;
         if (paddr == ADDR_CTRL) begin
            next_st.rdata[CTRL_EN] = st.amp_en;
         end else if (paddr == ADDR_STAT) begin
            next_st.rdata[STAT_MODE +: 3] = st.mode;
            next_st.rdata[STAT_GAIN +: 2] = st.gain;
            next_st.rdata[STAT_CLIP]      = st.clip_on;
            next_st.rdata[STAT_SLOPE]     = st.slope_low;
            next_st.rdata[STAT_DPSA]      = st.dpsa_off;
            next_st.rdata[STAT_BWE]       = st.bwe_on;
            next_st.rdata[STAT_CLK]       = st.idle_cnt < LOSS_CYC;
            next_st.rdata[STAT_FLT]       = flt_any;
         end
      end

      // DC block, gain and smoothing per selected bit
      if (bit_v) begin
         samp = st.dat_s2 ? AMP_POS : AMP_NEG;
         hp   = samp - $signed(st.dc);
         next_st.dc = st.dc + 18'(hp >>> HPF_SHIFT);
         case (st.gain)
            G_M3DB:  gsig = hp - (hp >>> 2) - (hp >>> 4);
            G_P3DB:  gsig = hp + (hp >>> 2) + (hp >>> 3) + (hp >>> 5);
            default: gsig = hp;
         endcase
         dlt = gsig - $signed(st.lvl);
         next_st.lvl = st.lvl + 18'(dlt >>> LPF_SHIFT);
      end

      // Duty with optional soft limit
      lim = st.clip_on ? CLIP_LIM : DUTY_MAX;
      lv  = $signed(st.lvl) >>> DUTY_SH;
      if (lv > $signed({10'h000, lim})) begin
         duty = lim;
      end else if (lv < -$signed({10'h000, lim})) begin
         duty = 8'h00 - lim;
      end else begin
         duty = lv[7:0];
      end

      // Three-level PWM: zero input gives equal in-phase pulses
      half = {duty[7], duty[7], duty[7:1]};
      next_st.pwm_cnt = st.pwm_cnt + 8'h01;
      next_st.out_a   = {1'b0, st.pwm_cnt} < (PWM_MID + half);
      next_st.out_b   = {1'b0, st.pwm_cnt} < (PWM_MID - half);

      // Only operating drives the stages
      if (next_st.mode == MD_OPER) begin
         next_st.oe_n = 1'b0;
      end else begin
         next_st.oe_n  = 1'b1;
         next_st.out_a = 1'b0;
         next_st.out_b = 1'b0;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st          <= '0;
         st.mode     <= MD_PD_CLK;
         st.gain     <= G_0DB;
         st.amp_en   <= CTRL_EN_RST;
         st.idle_cnt <= LOSS_CYC;
         st.last_id  <= ID_NONE;
         st.oe_n     <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Cycles spent in power-up, for checking only
   logic [TON_W:0] pu_age;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pu_age <= '0;
      end else if (st.mode == MD_POWERUP) begin
         pu_age <= pu_age + 1'b1;
      end else begin
         pu_age <= '0;
      end
   end

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_clk_loss_pd: assert property (lost |=> st.mode == MD_PD_CLK && st.oe_n)
      else $error("clock loss did not power down");
   a_clk_wake: assert property (st.mode == MD_PD_CLK && clk_rise && st.amp_en |=> st.mode == MD_POWERUP)
      else $error("clock edge did not start power-up");
   a_pd_entry: assert property (st.mode == MD_OPER && byte_v && hit_id == ID_PD && run_nx == PD_CNT
                                && !lost && !flt_any && st.amp_en |=> st.mode == MD_PD_PAT)
      else $error("128th power-down byte ignored");
   a_pd_release: assert property (st.mode == MD_PD_PAT && byte_v && hit_id != ID_PD && !lost && !flt_any
                                  && st.amp_en |=> st.mode == MD_OPER)
      else $error("pattern power-down not released");
   a_mute_entry: assert property (st.mode == MD_OPER && byte_v && hit_id == ID_MUTE && run_nx == MUTE_CNT
                                  && !lost && !flt_any && st.amp_en |=> st.mode == MD_MUTE)
      else $error("32nd mute byte ignored");
   a_mute_hold: assert property (st.mode == MD_MUTE && !byte_v && !lost && !flt_any && st.amp_en
                                 |=> st.mode == MD_MUTE)
      else $error("mute left without a byte");
   a_mute_float: assert property (st.mode != MD_OPER |-> st.oe_n && !st.out_a && !st.out_b)
      else $error("outputs driven outside operating");
   a_oper_drive: assert property (st.mode == MD_OPER |-> !st.oe_n)
      else $error("outputs floating in operating");
   a_fault_entry: assert property (flt_any && !lost && st.amp_en && st.mode != MD_PD_CLK
                                   |=> st.mode == MD_FAULT)
      else $error("protection did not enter fault");
   a_powerup_time: assert property (pu_age <= PU_MAX)
      else $error("power-up took too long");
   a_pd_time: assert property ($rose(lost) |-> ##[1:A_TOFF] st.oe_n && st.mode == MD_PD_CLK)
      else $error("power-down too slow");
   a_rot_match: assert property (byte_v && byte_nx == 8'h59 |-> hit_id == ID_PD)
      else $error("rotated power-down byte missed");
   a_settings_lock: assert property (st.mode != MD_POWERUP && !apb_wr |=> $stable(st.gain) && $stable(st.clip_on))
      else $error("setting changed after power-up");
   a_run_restart: assert property (byte_v && hit_id != st.last_id |=> st.run <= 8'h01)
      else $error("run count not restarted");

   c_mute: cover property (st.mode == MD_OPER ##1 st.mode == MD_MUTE);
   c_pd_pat: cover property (st.mode == MD_OPER ##1 st.mode == MD_PD_PAT);
   c_powerup: cover property (st.mode == MD_POWERUP ##1 st.mode == MD_OPER);
   c_fault: cover property (st.mode == MD_FAULT);

endmodule : pimc_top

// ===== verification/pimc_pdm_src.sv
// Behavioural PDM source driving the bit clock and data pins
`timescale 1ns/1ps
module pimc_pdm_src (
   input  wire logic        pclk,
   input  wire logic        run,
   input  wire logic [7:0]  tx_byte,
   output logic             bit_clock,
   output logic             data_in,
   output logic [15:0]      byte_cnt
);
   logic [2:0] ph;
   logic [2:0] bi;
   logic [7:0] sh;

   initial begin
      ph = 3'h0;
      bi = 3'h0;
      sh = 8'h00;
      bit_clock = 1'b0;
      data_in = 1'b0;
      byte_cnt = 16'h0000;
   end

   // Eight pclk per bit gives a 5 MHz clock; left bit set 50 ns before each rise,
   // right slot set 50 ns before each fall
   always @(posedge pclk) begin
      if (!run) begin
         ph <= 3'h0;
         bi <= 3'h0;
         bit_clock <= 1'b0;
         data_in <= ~data_in; // Idle data never holds its last bit
      end else begin
         ph <= ph + 3'h1;
         bit_clock <= ph[2];
         if (ph == 3'h0) begin
            bi <= bi + 3'h1;
            if (bi == 3'h0) begin
               sh <= tx_byte;
               byte_cnt <= byte_cnt + 16'h0001;
            end
         end
         if (ph == 3'h2) begin
            data_in <= sh[3'h7 - (bi - 3'h1)]; // MSB first, bi already advanced
         end else if (ph == 3'h6) begin
            data_in <= 1'b0; // Right channel carries silence
         end
      end
   end
endmodule : pimc_pdm_src

// ===== verification/pimc_top_tb_top.sv
// Self-checking bench for the PDM input mode control block
`timescale 1ns/1ps
module pimc_top_tb_top;
   import pimc_pkg::*;
   localparam int TON = 8400; // Long enough for 128 setting bytes in power-up
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, bit_clock, data_in, run = 1'b0, e, chsel = 1'b0;
   logic [3:0] protect_fault = 4'h0;
   logic [7:0] tx_byte = 8'h01;
   logic [15:0] byte_cnt;
   logic nout, nout_oe_n, iout, iout_oe_n;
   int failures = 0, num_checks = 0, tog;
   logic [7:0] rp [8] = '{8'h66, 8'h66, 8'hcc, 8'h99, 8'hac, 8'hac, 8'h59, 8'hd2};
   int rn [8] = '{31, 32, 32, 40, 127, 128, 130, 128};
   pimc_mode_e rm [8] = '{MD_OPER, MD_MUTE, MD_MUTE, MD_MUTE, MD_OPER, MD_PD_PAT, MD_PD_PAT, MD_OPER};

   always #12.5 pclk = ~pclk;

   pimc_top #(.TON_CYC(TON)) i_pimc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bit_clock(bit_clock), .data_in(data_in), .channel_select_input(chsel), .protect_fault(protect_fault),
      .noninverting_output(nout), .noninverting_output_oe_n(nout_oe_n), .inverting_output(iout),
      .inverting_output_oe_n(iout_oe_n));

   pimc_pdm_src i_pimc_pdm_src (.pclk(pclk), .run(run), .tx_byte(tx_byte), .bit_clock(bit_clock),
      .data_in(data_in), .byte_cnt(byte_cnt));

   task automatic close_out();
      $display("checks %0d, mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      num_checks++;
      if (got !== ex) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
         failures++;
      end
   endtask : chk

   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         failures++;
         close_out();
      end
   endtask : apb

   // Mode field and both enables against one expected mode
   task automatic chk_mode(input pimc_mode_e m);
      logic fl;
      fl = (m == MD_OPER) ? 1'b0 : 1'b1;
      apb(1'b0, ADDR_STAT, 32'h0);
      chk("mode", 32'(m), 32'(q[2:0]));
      chk("oe_n", {30'h0, fl, fl}, {30'h0, nout_oe_n, iout_oe_n});
   endtask : chk_mode

   // Waits until n more bytes have been started by the source
   task automatic send(input logic [7:0] b, input int n);
      int t0, k;
      @(posedge pclk);
      tx_byte <= b;
      t0 = int'(byte_cnt);
      k = 0;
      while (int'(byte_cnt) != t0 + n && k < 80 * n + 200) begin
         @(posedge pclk);
         k++;
      end
      if (k >= 80 * n + 200) begin
         failures++;
         close_out();
      end
      repeat (10) @(posedge pclk);
   endtask : send

   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      // Reset state, register access and an unmapped read
      chk_mode(MD_PD_CLK);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("ctrl", 32'h1, q);
      apb(1'b0, 12'h010, 32'h0);
      chk("err", 32'h1, {31'h0, e});
      apb(1'b1, ADDR_CTRL, 32'h1);
      // Clock start: power-up takes a gain pattern, then operating
      @(posedge pclk);
      run <= 1'b1;
      tx_byte <= 8'hd4;
      send(8'hd4, 128);
      send(8'h01, 1);
      chk_mode(MD_POWERUP);
      chk("gain", 32'(G_M3DB), 32'(q[STAT_GAIN +: 2]));
      repeat (250) @(posedge pclk); // Power-up ends TON cycles after the first rise
      chk_mode(MD_OPER);
      tog = 0;
      repeat (600) begin
         @(posedge pclk);
         if ((nout ^ iout) === 1'b1) tog++;
      end
      chk("switching", 32'h1, 32'(tog > 0));
      // Pattern rows: run, then one other byte, then operating again
      for (int r = 0; r < 8; r++) begin
         send(rp[r], rn[r]);
         send(8'h01, 1);
         chk_mode(rm[r]);
         send(8'h01, 1);
         chk_mode(MD_OPER);
      end
      // Settings survive the ignored clip pattern, a default write restores them
      chk("locked", 32'h0, {29'h0, q[STAT_CLIP], q[STAT_GAIN +: 2]});
      apb(1'b1, ADDR_CTRL, 32'h3);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk("defaults", 32'(G_0DB), 32'(q[STAT_GAIN +: 2]));
      // Each protection flag forces fault, clearing returns to operating
      for (int i = 0; i < 4; i++) begin
         @(posedge pclk);
         protect_fault <= 4'h1 << i;
         repeat (8) @(posedge pclk);
         apb(1'b0, ADDR_STAT, 32'h0);
         chk("fault", 32'(MD_FAULT), 32'(q[2:0]));
         protect_fault <= 4'h0;
         repeat (8) @(posedge pclk);
         chk_mode(MD_OPER);
      end
      // Right channel carries silence, so a left mute run must not act
      @(posedge pclk);
      chsel <= 1'b1;
      send(8'h66, 32);
      send(8'h01, 1);
      chk_mode(MD_OPER);
      chsel <= 1'b0;
      // Reset in mid-run floats the stages, the running clock wakes it again
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("rst_oe_n", 32'h3, {30'h0, nout_oe_n, iout_oe_n});
      presetn <= 1'b1;
      repeat (20) @(posedge pclk);
      chk_mode(MD_POWERUP);
      // Clock stop powers down well inside 5 us
      @(posedge pclk);
      run <= 1'b0;
      repeat (150) @(posedge pclk);
      chk_mode(MD_PD_CLK);
      close_out();
   end
endmodule : pimc_top_tb_top
